// ===== logic/rsw_pkg.sv
// Purpose: Constants and types of the clock/elapsed-time counter core
// Assumes: Byte-level register port behind the serial bus front end
// Notes:   Register map bytes, field masks and the tick prescaler figures
package rsw_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_HUND     = 8'h00;
  localparam logic [7:0] ADDR_SEC      = 8'h01;
  localparam logic [7:0] ADDR_MIN      = 8'h02;
  localparam logic [7:0] ADDR_TIME_TOP = 8'h07;
  localparam logic [7:0] ADDR_ALM_BASE = 8'h08;
  localparam logic [7:0] ADDR_ALM_TOP  = 8'h0F;
  localparam logic [7:0] ADDR_ALM_EN   = 8'h10;
  localparam logic [7:0] ADDR_FUNC     = 8'h28;
  localparam logic [7:0] ADDR_IRQ_A_EN = 8'h29;
  localparam logic [7:0] ADDR_IRQ_B_EN = 8'h2A;
  localparam logic [7:0] ADDR_FLAGS    = 8'h2B;
  localparam logic [7:0] ADDR_HALT     = 8'h2E;
  localparam logic [7:0] ADDR_RESETS   = 8'h2F;

  // Field positions
  localparam int unsigned BIT_OS        = 7;
  localparam int unsigned BIT_EVENT_SUMMARY_FLAG      = 7;
  localparam int unsigned BIT_HUND_EN   = 7;
  localparam int unsigned BIT_MODE_SEL  = 4;
  localparam int unsigned BIT_A1_IE     = 4;
  localparam int unsigned BIT_A2_IE     = 3;
  localparam int unsigned BIT_A2_FLAG   = 6;
  localparam int unsigned BIT_A1_FLAG   = 5;
  localparam int unsigned BIT_HALT      = 0;
  localparam logic [7:0]  PRESC_CLEAR_CODE = 8'hA4;

  // Timebase: 32768 Hz edges turned into an exact-average 100 Hz tick
  localparam int unsigned TIMEBASE_HZ = 32768;
  localparam int unsigned TICK_HZ     = 100;
  localparam logic [16:0] PRESC_MOD   = 17'(TIMEBASE_HZ);
  localparam logic [16:0] PRESC_STEP  = 17'(TICK_HZ);

  // Time storage: eight BCD bytes at offsets 00h..07h
  typedef logic [7:0][7:0] rsw_bytes_t;

  // Calendar default 2000-01-01 Saturday 00:00:00.00
  localparam rsw_bytes_t TIME_RST_CAL = {8'h00, 8'h01, 8'h06, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam rsw_bytes_t TIME_RST_SW  = '0;

  // Implemented bits per time byte, calendar then elapsed-time layout
  localparam rsw_bytes_t MASK_CAL = {8'hFF, 8'h1F, 8'h07, 8'h3F, 8'h3F, 8'h7F, 8'h7F, 8'hFF};
  localparam rsw_bytes_t MASK_SW  = {8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF};

  // Which time byte each alarm slot 08h..0Fh compares with
  localparam logic [7:0][2:0] ALM_IDX_CAL = {3'd5, 3'd3, 3'd2, 3'd6, 3'd4, 3'd3, 3'd2, 3'd1};
  localparam logic [7:0][2:0] ALM_IDX_SW  = {3'd4, 3'd3, 3'd2, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1};

  // Byte-level request from the serial bus front end
  typedef struct packed {
    logic       start;     // Start of a transfer, takes a new snapshot
    logic       addr_load; // With start: addr carries a register pointer
    logic [7:0] addr;
    logic       wr;        // One data byte written at the pointer
    logic [7:0] wdata;
    logic       rd;        // One data byte requested at the pointer
  } rsw_bus_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rsw_bus_rsp_t;

endpackage : rsw_pkg

// ===== logic/rsw_core.sv
// Purpose: Clock/calendar and elapsed-time counter with two alarms
// Assumes: i_bus is decoded from the serial bus on i_clk; i_tick_32k and i_osc_ok come from pins
// Notes:   Calendar hours always counted in 24 h form
// How it works
// - weekday is 3 bits, 0 through 6
// - month BCD 01..12, tens in bit 4
// - read start copies bytes 00h-07h, counting continues
// - A4h after halt register clears prescaler
// - writing 00h to halt resumes counting
// - 100 Hz tick advances fields with carry
// - elapsed-time fields are two-digit BCD bytes
// - mode bit 1 selects elapsed-time counting
// - six-digit hours in bytes 03h-05h
// - bytes 06h, 07h read zero in elapsed mode; unused bits read zero
// - hundredths reads zero unless enabled
// - reset: 2000-01-01 Saturday 00:00:00.00, stop flag one
// - two independent alarms raising interrupts
// - calendar alarm fields individually enabled
// - elapsed alarms compare time; route to either output
// - oscillator stop flag sticky until cleared
// - summary flag mirrors flags, not writable
// - February gets day 29 when year divisible by 4
`timescale 1ns/10ps
`default_nettype none

module rsw_core
  import rsw_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // Timebase pins
  input  wire logic                  i_tick_32k,
  input  wire logic                  i_osc_ok,
  // Register port
  input  wire rsw_pkg::rsw_bus_req_t i_bus,
  output var  rsw_pkg::rsw_bus_rsp_t o_rsp,
  // Interrupts
  output var  logic                  o_irq_out_first_n,
  output var  logic                  o_irq_out_second_n
);

  typedef struct packed {
    logic [2:0]   tk_sync;
    logic         tk_lvl;
    logic [2:0]   osc_sync;
    logic         osc_lvl;
    logic [16:0]  presc;
    rsw_bytes_t   t;
    rsw_bytes_t   snap;
    rsw_bytes_t   alm;
    logic [7:0]   alm_en;
    logic         hundredths_enable;
    logic         counter_mode_select;
    logic [7:0]   irq_a_en;
    logic [7:0]   irq_b_en;
    logic [1:0]   flags;        // [1] alarm2, [0] alarm1
    logic         osc_stopped_flag;
    logic         halt;
    logic [7:0]   ptr;
    rsw_bus_rsp_t rsp;
    logic         irq_a_n;
    logic         irq_b_n;
  } rsw_state_t;

  rsw_state_t st_ff;
  rsw_state_t nxt_st;

  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] n;
    n = v;
    if (v[3:0] == 4'h9)
    begin
      n = {v[7:4] + 4'h1, 4'h0};
    end
    else
    begin
      n[3:0] = v[3:0] + 4'h1;
    end
    return (v >= hi) ? {1'b1, lo} : {1'b0, n};
  endfunction : bcd_inc

  function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
    logic [7:0] ybin;
    ybin = ({4'h0, yr[7:4]} * 8'd10) + {4'h0, yr[3:0]};
    if (mon == 8'h02)
    begin
      return (ybin[1:0] == 2'b00) ? 8'h29 : 8'h28;
    end
    if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
    begin
      return 8'h30;
    end
    return 8'h31;
  endfunction : days_in_month

  function automatic logic [7:0] field_mask(input logic [2:0] idx, input logic sw);
    return sw ? MASK_SW[idx] : MASK_CAL[idx];
  endfunction : field_mask

  // Alarm 1 uses slots 0..4, alarm 2 slots 5..7; no enabled field means no alarm
  function automatic logic [1:0] alarm_hit(input rsw_bytes_t tm, input rsw_bytes_t am,
                                           input logic [7:0] en, input logic sw);
    logic [7:0] eq;
    logic [2:0] idx;
    eq = '0;
    for (int i = 0; i < 8; i++)
    begin
      idx   = sw ? ALM_IDX_SW[i] : ALM_IDX_CAL[i];
      eq[i] = !en[i] || ((tm[idx] & field_mask(idx, sw)) == (am[i] & field_mask(idx, sw)));
    end
    return {(|en[7:5]) && (&eq[7:5]), (|en[4:0]) && (&eq[4:0])};
  endfunction : alarm_hit

  always_comb
  begin
    logic       tick_edge;
    logic       tick;
    logic       c;
    logic [8:0] r;
    logic [16:0] sum;
    logic [1:0] hit_old;
    logic [1:0] hit_new;
    logic [2:0] bi;
    logic [7:0] rd;
    rsw_bytes_t tm;
    tick_edge = 1'b0;
    tick      = 1'b0;
    c         = 1'b0;
    r         = '0;
    sum       = '0;
    bi        = '0;
    rd        = '0;
    hit_old   = '0;
    hit_new   = '0;
    tm        = st_ff.t;
    nxt_st    = st_ff;
    nxt_st.rsp.valid = 1'b0;

    // Pin synchronisers; a level counts once the second and third stage agree
    nxt_st.tk_sync  = {st_ff.tk_sync[1:0], i_tick_32k};
    nxt_st.osc_sync = {st_ff.osc_sync[1:0], i_osc_ok};
    if (st_ff.tk_sync[2] == st_ff.tk_sync[1])
    begin
      nxt_st.tk_lvl = st_ff.tk_sync[2];
      tick_edge     = st_ff.tk_sync[2] && !st_ff.tk_lvl;
    end
    if (st_ff.osc_sync[2] == st_ff.osc_sync[1])
    begin
      nxt_st.osc_lvl = st_ff.osc_sync[2];
    end

    // Phase accumulator gives 100 ticks per 32768 edges with no long-term drift
    if (st_ff.halt)
    begin
      nxt_st.presc = '0;
    end
    else if (tick_edge)
    begin
      sum = st_ff.presc + PRESC_STEP;
      if (sum >= PRESC_MOD)
      begin
        sum  = sum - PRESC_MOD;
        tick = 1'b1;
      end
      nxt_st.presc = sum;
    end

    // Counter chain
    tm = st_ff.t;
    if (tick)
    begin
      r = bcd_inc(tm[0], 8'h99, 8'h00);
      tm[0] = r[7:0];
      c = r[8];
      if (c)
      begin
        r = bcd_inc(tm[1], 8'h59, 8'h00);
        tm[1] = r[7:0];
        c = r[8];
      end
      if (c)
      begin
        r = bcd_inc(tm[2], 8'h59, 8'h00);
        tm[2] = r[7:0];
        c = r[8];
      end
      if (st_ff.counter_mode_select)
      begin
        for (int i = 3; i < 6; i++)
        begin
          if (c)
          begin
            r = bcd_inc(tm[i], 8'h99, 8'h00);
            tm[i] = r[7:0];
            c = r[8];
          end
        end
      end
      else
      begin
        if (c)
        begin
          r = bcd_inc(tm[3], 8'h23, 8'h00);
          tm[3] = r[7:0];
          c = r[8];
        end
        if (c)
        begin
          r = bcd_inc(tm[5], 8'h06, 8'h00);
          tm[5] = r[7:0];
          r = bcd_inc(tm[4], days_in_month(tm[6], tm[7]), 8'h01);
          tm[4] = r[7:0];
          c = r[8];
        end
        if (c)
        begin
          r = bcd_inc(tm[6], 8'h12, 8'h01);
          tm[6] = r[7:0];
          c = r[8];
        end
        if (c)
        begin
          r = bcd_inc(tm[7], 8'h99, 8'h00);
          tm[7] = r[7:0];
        end
      end
    end

    // Alarm flags set on the tick that first reaches a match
    hit_old = alarm_hit(st_ff.t, st_ff.alm, st_ff.alm_en, st_ff.counter_mode_select);
    hit_new = alarm_hit(tm, st_ff.alm, st_ff.alm_en, st_ff.counter_mode_select);

    // Bus transfer start: pointer load and snapshot
    if (i_bus.start)
    begin
      nxt_st.snap = st_ff.t;
      if (i_bus.addr_load)
      begin
        nxt_st.ptr = i_bus.addr;
      end
    end

    if (i_bus.wr)
    begin
      bi = st_ff.ptr[2:0];
      if (st_ff.ptr <= ADDR_TIME_TOP)
      begin
        // Write wins over a same-cycle tick for the addressed byte
        tm[bi] = i_bus.wdata & field_mask(bi, st_ff.counter_mode_select);
        if (st_ff.ptr == ADDR_SEC && !i_bus.wdata[BIT_OS])
        begin
          nxt_st.osc_stopped_flag = 1'b0;
        end
      end
      else if (st_ff.ptr <= ADDR_ALM_TOP)
      begin
        nxt_st.alm[bi] = i_bus.wdata;
      end
      unique case (st_ff.ptr)
        ADDR_ALM_EN:   nxt_st.alm_en = i_bus.wdata;
        ADDR_FUNC:
        begin
          nxt_st.hundredths_enable   = i_bus.wdata[BIT_HUND_EN];
          nxt_st.counter_mode_select = i_bus.wdata[BIT_MODE_SEL];
        end
        ADDR_IRQ_A_EN: nxt_st.irq_a_en = i_bus.wdata;
        ADDR_IRQ_B_EN: nxt_st.irq_b_en = i_bus.wdata;
        ADDR_FLAGS:
        begin
          // Writing 0 clears a flag, writing 1 leaves it
          nxt_st.flags[1] = st_ff.flags[1] && i_bus.wdata[BIT_A2_FLAG];
          nxt_st.flags[0] = st_ff.flags[0] && i_bus.wdata[BIT_A1_FLAG];
        end
        ADDR_HALT:     nxt_st.halt = i_bus.wdata[BIT_HALT];
        ADDR_RESETS:
        begin
          if (i_bus.wdata == PRESC_CLEAR_CODE)
          begin
            nxt_st.presc = '0;
          end
        end
        default: ;
      endcase
    end
    nxt_st.t = tm;

    // Set wins over a clear in the same cycle
    if (tick)
    begin
      nxt_st.flags = nxt_st.flags | (hit_new & ~hit_old);
    end
    if (!st_ff.osc_lvl)
    begin
      nxt_st.osc_stopped_flag = 1'b1;
    end

    if (i_bus.rd)
    begin
      bi = st_ff.ptr[2:0];
      if (st_ff.ptr <= ADDR_TIME_TOP)
      begin
        rd = st_ff.snap[bi] & field_mask(bi, st_ff.counter_mode_select);
        if (st_ff.ptr == ADDR_HUND && !st_ff.hundredths_enable)
        begin
          rd = '0;
        end
        if (st_ff.ptr == ADDR_SEC)
        begin
          rd[BIT_OS] = st_ff.osc_stopped_flag;
        end
        if (st_ff.ptr == ADDR_MIN)
        begin
          rd[BIT_EVENT_SUMMARY_FLAG] = |st_ff.flags;
        end
      end
      else if (st_ff.ptr <= ADDR_ALM_TOP)
      begin
        rd = st_ff.alm[bi];
      end
      unique case (st_ff.ptr)
        ADDR_ALM_EN:   rd = st_ff.alm_en;
        ADDR_FUNC:
        begin
          rd[BIT_HUND_EN]  = st_ff.hundredths_enable;
          rd[BIT_MODE_SEL] = st_ff.counter_mode_select;
        end
        ADDR_IRQ_A_EN: rd = st_ff.irq_a_en;
        ADDR_IRQ_B_EN: rd = st_ff.irq_b_en;
        ADDR_FLAGS:
        begin
          rd[BIT_A2_FLAG] = st_ff.flags[1];
          rd[BIT_A1_FLAG] = st_ff.flags[0];
        end
        ADDR_HALT:     rd[BIT_HALT] = st_ff.halt;
        default: ;
      endcase
      nxt_st.rsp.data  = rd;
      nxt_st.rsp.valid = 1'b1;
    end

    if (i_bus.wr || i_bus.rd)
    begin
      nxt_st.ptr = nxt_st.ptr + 8'h01;
    end

    // Either alarm may be routed to either output
    nxt_st.irq_a_n = !((nxt_st.flags[0] && st_ff.irq_a_en[BIT_A1_IE]) ||
                       (nxt_st.flags[1] && st_ff.irq_a_en[BIT_A2_IE]));
    nxt_st.irq_b_n = !((nxt_st.flags[0] && st_ff.irq_b_en[BIT_A1_IE]) ||
                       (nxt_st.flags[1] && st_ff.irq_b_en[BIT_A2_IE]));
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_ff                  <= '0;
      st_ff.t                <= TIME_RST_CAL;
      st_ff.snap             <= TIME_RST_CAL;
      st_ff.osc_stopped_flag <= 1'b1;
      st_ff.irq_a_n          <= 1'b1;
      st_ff.irq_b_n          <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_rsp              = st_ff.rsp;
  assign o_irq_out_first_n  = st_ff.irq_a_n;
  assign o_irq_out_second_n = st_ff.irq_b_n;

endmodule : rsw_core

`default_nettype wire

// ===== tb/rsw_core_checker.sv
// Purpose: Port-level assertions for the time counter core
// Assumes: Byte register port as declared in rsw_pkg
// Notes:   Pointer and config bits mirrored from observed writes
`timescale 1ns/10ps
`default_nettype none
module rsw_core_checker
  import rsw_pkg::*;
(
  // Clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  // Observed ports
  input wire rsw_pkg::rsw_bus_req_t i_bus,
  input wire rsw_pkg::rsw_bus_rsp_t o_rsp,
  input wire logic                  o_irq_out_first_n,
  input wire logic                  o_irq_out_second_n
);
  logic [7:0] ptr_ff;
  logic       mode_ff;
  logic       hund_ff;
  logic       ena_ff;

  // Increment lands on top of a same-cycle load, as the port does
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ptr_ff  <= 8'h00;
      mode_ff <= 1'b0;
      hund_ff <= 1'b0;
      ena_ff  <= 1'b0;
    end
    else
    begin
      if (i_bus.start && i_bus.addr_load)
        ptr_ff <= i_bus.addr + ((i_bus.wr || i_bus.rd) ? 8'h01 : 8'h00);
      else if (i_bus.wr || i_bus.rd)
        ptr_ff <= ptr_ff + 8'h01;
      if (i_bus.wr && ptr_ff == ADDR_FUNC)
      begin
        mode_ff <= i_bus.wdata[BIT_MODE_SEL];
        hund_ff <= i_bus.wdata[BIT_HUND_EN];
      end
      if (i_bus.wr && ptr_ff == ADDR_IRQ_A_EN)
        ena_ff <= i_bus.wdata[BIT_A1_IE] | i_bus.wdata[BIT_A2_IE];
    end
  end

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_RSP_AFTER_RD: assert property (i_bus.rd |=> o_rsp.valid)
    else $error("read without answer");
  AST_NO_SPURIOUS: assert property (!i_bus.rd |=> !o_rsp.valid)
    else $error("answer without read");
  AST_DATA_HOLD: assert property (!o_rsp.valid |-> $stable(o_rsp.data))
    else $error("read data moved without answer");
  AST_RESET_IDLE: assert property ($fell(i_rst) |-> o_rsp == '0 && o_irq_out_first_n && o_irq_out_second_n)
    else $error("outputs not idle after reset");
  AST_WEEKDAY: assert property (i_bus.rd && ptr_ff == 8'h05 && !mode_ff
    |=> o_rsp.data[7:3] == 5'h00 && o_rsp.data[2:0] != 3'h7)
    else $error("weekday out of range");
  AST_MONTH: assert property (i_bus.rd && ptr_ff == 8'h06 && !mode_ff |=> o_rsp.data[7:5] == 3'h0
    && o_rsp.data[4:0] != 5'h00 && o_rsp.data[3:0] <= (o_rsp.data[4] ? 4'h2 : 4'h9))
    else $error("month out of range");
  AST_SW_UNUSED: assert property (i_bus.rd && mode_ff && ptr_ff[7:1] == 7'h03 |=> o_rsp.data == 8'h00)
    else $error("unused elapsed byte not zero");
  AST_HUND_OFF: assert property (i_bus.rd && ptr_ff == ADDR_HUND && !hund_ff |=> o_rsp.data == 8'h00)
    else $error("hundredths visible while disabled");
  AST_SW_BCD: assert property (i_bus.rd && mode_ff && ptr_ff inside {8'h03, 8'h04, 8'h05}
    |=> o_rsp.data[7:4] <= 4'h9 && o_rsp.data[3:0] <= 4'h9)
    else $error("elapsed hours not BCD");
  AST_IRQ_QUIET: assert property (!ena_ff && !$past(ena_ff) |-> o_irq_out_first_n)
    else $error("interrupt with enables off");
endmodule : rsw_core_checker

bind rsw_core rsw_core_checker u_chk (
  .i_clk              (i_clk),
  .i_rst              (i_rst),
  .i_bus              (i_bus),
  .o_rsp              (o_rsp),
  .o_irq_out_first_n  (o_irq_out_first_n),
  .o_irq_out_second_n (o_irq_out_second_n)
);
`default_nettype wire

// ===== tb/rsw_host_model.sv
// Purpose: Host side of the register port, byte requests
// Assumes: One request per pulse, idle cycle between
// Notes:   Read data taken just after the answering edge
`timescale 1ns/10ps
`default_nettype none
module rsw_host_model
  import rsw_pkg::*;
(
  // Clock
  input wire logic                  i_clk,
  // Register port
  output var rsw_pkg::rsw_bus_req_t o_bus,
  input wire rsw_pkg::rsw_bus_rsp_t i_rsp
);
  initial o_bus = '0;

  task automatic go(input logic s, input logic w, input logic r, input logic [7:0] v);
    rsw_bus_req_t q;
    q = '0;
    q.start = s;
    q.addr_load = s;
    q.addr = v;
    q.wr = w;
    q.wdata = v;
    q.rd = r;
    @(posedge i_clk);
    o_bus <= q;
    @(posedge i_clk);
    o_bus <= '0;
  endtask : go

  task automatic rd(output logic [7:0] d);
    go(1'b0, 1'b0, 1'b1, 8'h00);
    #1;
    d = i_rsp.data;
  endtask : rd

  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    go(1'b1, 1'b0, 1'b0, a);
    go(1'b0, 1'b1, 1'b0, d);
  endtask : wr1

  // Halt and prescaler clear first, then whole time in one burst, so no carry lands between fields
  task automatic load(input logic [63:0] v);
    go(1'b1, 1'b0, 1'b0, ADDR_HALT);
    go(1'b0, 1'b1, 1'b0, 8'h01);
    go(1'b0, 1'b1, 1'b0, PRESC_CLEAR_CODE);
    go(1'b1, 1'b0, 1'b0, ADDR_HUND);
    for (int i = 0; i < 8; i++)
      go(1'b0, 1'b1, 1'b0, v[63 - 8 * i -: 8]);
  endtask : load

  task automatic run();
    wr1(ADDR_HALT, 8'h00);
  endtask : run
endmodule : rsw_host_model
`default_nettype wire

// ===== tb/rtc_stopwatch_time_counter_bench.sv
// Purpose: Self-checking bench of the time counter core
// Assumes: 8 clocks per timebase period, oscillator stable
// Notes:   Carries tested from loaded near-rollover times
`timescale 1ns/10ps
`default_nettype none
module rtc_stopwatch_time_counter_bench;
  import rsw_pkg::*;
  logic         i_clk = 1'b0;
  logic         i_rst = 1'b1;
  logic         i_tick_32k = 1'b0;
  logic         i_osc_ok = 1'b1;
  rsw_bus_req_t bus;
  rsw_bus_rsp_t rsp;
  logic         irq_a_n;
  logic         irq_b_n;
  int           errors = 0;
  int           comparisons = 0;

  always #5 i_clk = ~i_clk;

  rsw_core uut (
    .i_clk              (i_clk),
    .i_rst              (i_rst),
    .i_tick_32k         (i_tick_32k),
    .i_osc_ok           (i_osc_ok),
    .i_bus              (bus),
    .o_rsp              (rsp),
    .o_irq_out_first_n  (irq_a_n),
    .o_irq_out_second_n (irq_b_n)
  );
  rsw_host_model host (.i_clk(i_clk), .o_bus(bus), .i_rsp(rsp));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd1(input logic [7:0] e);
    logic [7:0] d;
    host.rd(d);
    check(d, e);
  endtask : rd1

  task automatic rd8(input logic [63:0] e);
    logic [7:0] d;
    for (int i = 0; i < 8; i++)
    begin
      host.rd(d);
      check(d, e[63 - 8 * i -: 8]);
    end
  endtask : rd8

  // Each edge spans 8 clocks to clear the input synchroniser
  task automatic edges(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      i_tick_32k <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_tick_32k <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask : edges

  task automatic t_reset();
    host.go(1'b1, 1'b0, 1'b0, ADDR_HUND);
    rd8(64'h0080_0000_0106_0100);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_calendar();
    host.load(64'h9959_5923_2806_0204);
    host.go(1'b1, 1'b0, 1'b0, ADDR_HUND);
    rd1(8'h00);
    host.wr1(ADDR_FUNC, 8'h80);
    host.run();
    edges(320);
    host.go(1'b1, 1'b0, 1'b0, ADDR_HUND);
    rd1(8'h99);
    edges(20);
    rd1(8'h59);
    host.go(1'b1, 1'b0, 1'b0, ADDR_HUND);
    rd8(64'h0000_0000_2900_0204);
    $display("t_calendar done");
  endtask : t_calendar

  task automatic t_elapsed();
    host.wr1(ADDR_FUNC, 8'h90);
    host.load(64'h9959_5999_9900_5555);
    host.run();
    edges(340);
    host.go(1'b1, 1'b0, 1'b0, ADDR_HUND);
    rd8(64'h0000_0000_0001_0000);
    $display("t_elapsed done");
  endtask : t_elapsed

  // Alarm1 on seconds 01, routed to the first output only
  task automatic t_alarm();
    host.go(1'b1, 1'b0, 1'b0, ADDR_ALM_BASE);
    host.go(1'b0, 1'b1, 1'b0, 8'h01);
    host.wr1(ADDR_ALM_EN, 8'h01);
    host.wr1(ADDR_IRQ_A_EN, 8'h10);
    host.wr1(ADDR_IRQ_B_EN, 8'h08);
    host.load(64'h9900_0000_0000_0000);
    host.run();
    edges(330);
    host.go(1'b1, 1'b0, 1'b0, ADDR_FLAGS);
    rd1(8'h20);
    check({7'h00, irq_a_n}, 8'h00);
    check({7'h00, irq_b_n}, 8'h01);
    host.go(1'b1, 1'b0, 1'b0, ADDR_MIN);
    rd1(8'h80);
    host.wr1(ADDR_FLAGS, 8'h00);
    host.go(1'b1, 1'b0, 1'b0, ADDR_MIN);
    rd1(8'h00);
    check({7'h00, irq_a_n}, 8'h01);
    $display("t_alarm done");
  endtask : t_alarm

  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_calendar();
    t_elapsed();
    t_alarm();
    stop_test();
  end

  // Tests need about 83 us
  initial
  begin
    #200000;
    errors++;
    stop_test();
  end
endmodule : rtc_stopwatch_time_counter_bench
`default_nettype wire
